// ===== rtl/ise_flags_top.sv
// Added by the designer: the AXI4-Lite slave port and the address map.
module ise_flags_top #(
    parameter int N_ADDR = 4
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [ise_pkg::AW-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [ise_pkg::DW-1:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [ise_pkg::AW-1:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [ise_pkg::DW-1:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic i_scl,
    output logic o_scl_o,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic i_dma_ack,
    output logic o_dma_req,
    output logic o_irq
);
    import ise_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0] rst_sync_r;
    wire rst_n = rst_sync_r[1];

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    logic [1:0] pins_s;
    logic scl_q_r;
    logic sda_q_r;

    ise_sync2 #(.WIDTH(2)) u_sync (
        .i_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_async({i_scl, i_sda}),
        .o_sync(pins_s)
    );

    wire scl_s = pins_s[1];
    wire sda_s = pins_s[0];

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_q_r;
    wire scl_fall = ~scl_s & scl_q_r;
    wire start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
    wire stop_det = scl_s & scl_q_r & ~sda_q_r & sda_s;

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic [AW-1:0] awaddr_r;
    logic [DW-1:0] wdata_r;
    logic [3:0] wstrb_r;

    // Address and data are taken independently; the write acts once both are held
    wire wr_fire = ~awready_r & ~wready_r & ~bvalid_r;
    wire [DW-1:0] be_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}},
                             {8{wstrb_r[0]}}};
    wire [DW-1:0] wval = wdata_r & be_mask;

    wire wr_sctl = wr_fire & (awaddr_r == OFS_SLV_CTRL);
    wire wr_mctl = wr_fire & (awaddr_r == OFS_MST_CTRL);
    wire wr_stat = wr_fire & (awaddr_r == OFS_STAT);
    wire wr_iset = wr_fire & (awaddr_r == OFS_INTEN_SET);
    wire wr_iclr = wr_fire & (awaddr_r == OFS_INTEN_CLR);
    wire wr_sdat = wr_fire & (awaddr_r == OFS_SLV_DATA);
    logic [N_ADDR-1:0] wr_sa;
    wire wr_hit = wr_sctl | wr_mctl | wr_stat | wr_iset | wr_iclr | wr_sdat | (|wr_sa);

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (i_s_axi_awvalid && awready_r) begin
                awaddr_r <= i_s_axi_awaddr;
                awready_r <= 1'b0;
            end
            if (i_s_axi_wvalid && wready_r) begin
                wdata_r <= i_s_axi_wdata;
                wstrb_r <= i_s_axi_wstrb;
                wready_r <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && i_s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode
    ise_sctl_t sctl_wr;
    ise_mctl_t mctl_wr;
    ise_stat_t stat_wr;
    assign sctl_wr = ise_sctl_t'(wval);
    assign mctl_wr = ise_mctl_t'(wval);
    assign stat_wr = ise_stat_t'(wval);

    // Only ones act; zeros and reserved bit 7 are ignored
    wire slv_cont = wr_sctl & sctl_wr.cont;
    wire mst_cont = wr_mctl & mctl_wr.cont;
    wire mst_start = wr_mctl & mctl_wr.start;
    wire mst_stop = wr_mctl & mctl_wr.stop;
    wire err_w1c = wr_stat & stat_wr.mst_err;

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers
    logic slv_dma_en_r;
    logic [7:0] tx_r;
    logic [DW-1:0] inten_r;
    ise_saddr_t saddr_r [N_ADDR];

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slv_dma_en_r <= 1'b0;
            tx_r <= '0;
            inten_r <= '0;
        end else begin
            if (wr_sctl && wstrb_r[0]) begin
                slv_dma_en_r <= sctl_wr.dma_en;
            end
            if (wr_sdat && wstrb_r[0]) begin
                tx_r <= wval[7:0];
            end
            if (wr_iset || wr_iclr) begin
                inten_r <= (inten_r | ({DW{wr_iset}} & wval & INT_MASK))
                           & ~({DW{wr_iclr}} & wval);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Own-address registers and match
    logic [7:0] shift_r;
    logic [N_ADDR-1:0] match_v;
    logic [N_ADDR-1:0] rd_sa;
    logic [DW-1:0] sa_rd [N_ADDR];
    logic [DW-1:0] sa_or;

    for (genvar g = 0; g < N_ADDR; g++) begin : g_addr
        wire [AW-1:0] ofs = OFS_SLV_ADDR0 + AW'(g) * OFS_STEP;
        assign wr_sa[g] = wr_fire & (awaddr_r == ofs);
        assign rd_sa[g] = i_s_axi_araddr == ofs;
        assign match_v[g] = saddr_r[g].en & (saddr_r[g].addr == shift_r[7:1]);
        assign sa_rd[g] = {DW{rd_sa[g]}} & DW'(saddr_r[g]);

        always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
                saddr_r[g] <= '0;
            end else if (wr_sa[g] && wstrb_r[0]) begin
                saddr_r[g] <= ise_saddr_t'({24'h0, wval[7:0]});
            end
        end
    end

    always_comb begin
        sa_or = '0;
        for (int i = 0; i < N_ADDR; i++) begin
            sa_or = sa_or | sa_rd[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Master start/stop supervision
    logic mst_busy_r;
    logic err_r;
    logic [3:0] bus_cnt_r;

    // A frame boundary is after the ninth clock; anything else is mid-byte
    wire misplaced = (start_det | stop_det) & mst_busy_r & (bus_cnt_r != CNT_ZERO);

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_cnt_r <= CNT_ZERO;
            mst_busy_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            if (start_det || stop_det) begin
                bus_cnt_r <= CNT_ZERO;
            end else if (scl_rise) begin
                bus_cnt_r <= (bus_cnt_r == BYTE_BITS) ? CNT_ZERO : bus_cnt_r + 4'h1;
            end
            if (misplaced) begin
                mst_busy_r <= 1'b0;
            end else if (mst_start) begin
                mst_busy_r <= 1'b1;
            end else if (mst_stop) begin
                mst_busy_r <= 1'b0;
            end
            // Event beats a same-cycle clear
            if (misplaced) begin
                err_r <= 1'b1;
            end else if (err_w1c || mst_cont) begin
                err_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Slave sequencer
    ise_sl_state_t sl_state_r;
    ise_sl_state_t sl_nxt;
    ise_slv_code_t code_r;
    ise_slv_code_t hold_code;
    logic [3:0] bit_cnt_r;
    logic [7:0] txsh_r;
    logic [7:0] txsh_nxt;
    logic [7:0] rx_data_r;
    logic is_addr_r;
    logic rd_dir_r;
    logic ack_r;
    logic pend_r;
    logic dma_req_r;
    logic go_hold;
    logic sda_oe_nxt;

    wire hold_release = (sl_state_r == SL_HOLD) & (slv_cont | (dma_req_r & i_dma_ack));
    // DMA takes only data events; an address match always goes to software
    wire use_dma = slv_dma_en_r & (hold_code != SLV_CODE_ADDR);

    always_comb begin
        sl_nxt = sl_state_r;
        go_hold = 1'b0;
        hold_code = code_r;
        txsh_nxt = txsh_r;
        if (stop_det) begin
            sl_nxt = SL_IDLE;
        end else if (start_det) begin
            sl_nxt = SL_RX;
        end else begin
            unique case (sl_state_r)
                SL_IDLE: begin
                end
                SL_RX: begin
                    if (scl_fall && bit_cnt_r == BYTE_BITS) begin
                        if (!is_addr_r || (|match_v)) begin
                            go_hold = 1'b1;
                            sl_nxt = SL_HOLD;
                            hold_code = is_addr_r ? SLV_CODE_ADDR : SLV_CODE_RX;
                        end else begin
                            sl_nxt = SL_IDLE;
                        end
                    end
                end
                SL_HOLD: begin
                    if (hold_release) begin
                        sl_nxt = (code_r == SLV_CODE_TX) ? SL_TX : SL_ACK;
                        txsh_nxt = tx_r;
                    end
                end
                SL_ACK: begin
                    if (scl_fall) begin
                        if (rd_dir_r) begin
                            go_hold = 1'b1;
                            sl_nxt = SL_HOLD;
                            hold_code = SLV_CODE_TX;
                        end else begin
                            sl_nxt = SL_RX;
                        end
                    end
                end
                SL_TX: begin
                    if (scl_fall) begin
                        txsh_nxt = {txsh_r[6:0], 1'b0};
                        if (bit_cnt_r == LAST_BIT) begin
                            sl_nxt = SL_TXACK;
                        end
                    end
                end
                SL_TXACK: begin
                    if (scl_fall) begin
                        go_hold = ~ack_r;
                        sl_nxt = ack_r ? SL_IDLE : SL_HOLD;
                        hold_code = SLV_CODE_TX;
                    end
                end
                default: begin
                    sl_nxt = SL_IDLE;
                end
            endcase
        end
        sda_oe_nxt = (sl_nxt == SL_ACK) | ((sl_nxt == SL_TX) & ~txsh_nxt[7]);
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sl_state_r <= SL_IDLE;
            txsh_r <= '0;
            ack_r <= 1'b1;
        end else begin
            sl_state_r <= sl_nxt;
            txsh_r <= txsh_nxt;
            if (sl_state_r == SL_TXACK && scl_rise) begin
                ack_r <= sda_s;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_r <= CNT_ZERO;
            shift_r <= '0;
            is_addr_r <= 1'b0;
            rd_dir_r <= 1'b0;
            rx_data_r <= '0;
        end else if (start_det) begin
            bit_cnt_r <= CNT_ZERO;
            is_addr_r <= 1'b1;
            rd_dir_r <= 1'b0;
        end else if (sl_state_r == SL_RX && scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (sl_state_r == SL_RX && go_hold) begin
            if (is_addr_r) begin
                rd_dir_r <= shift_r[0];
            end else begin
                rx_data_r <= shift_r;
            end
        end else if (sl_state_r == SL_TX && scl_fall) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (sl_nxt != sl_state_r) begin
            bit_cnt_r <= CNT_ZERO;
            is_addr_r <= 1'b0;
        end
    end

    // Set beats clear: a new hold in the continue cycle stays pending
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            code_r <= SLV_CODE_ADDR;
            pend_r <= 1'b0;
            dma_req_r <= 1'b0;
        end else begin
            if (go_hold) begin
                code_r <= hold_code;
            end
            if (go_hold && !use_dma) begin
                pend_r <= 1'b1;
            end else if (slv_cont || sl_nxt == SL_IDLE) begin
                pend_r <= 1'b0;
            end
            if (go_hold && use_dma) begin
                dma_req_r <= 1'b1;
            end else if (i_dma_ack || slv_cont || sl_nxt == SL_IDLE) begin
                dma_req_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status word, read path and pins
    ise_stat_t stat_w;
    logic scl_oe_r;
    logic sda_oe_r;
    logic irq_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [DW-1:0] rdata_r;

    always_comb begin
        stat_w = '0;
        stat_w.mst_pend = ~mst_busy_r;
        stat_w.mst_code = mst_busy_r ? MST_CODE_BUSY : MST_CODE_IDLE;
        stat_w.mst_err = err_r;
        stat_w.slv_pend = pend_r;
        stat_w.slv_code = code_r;
        stat_w.slv_nstr = ~scl_oe_r;
    end

    wire rd_stat = i_s_axi_araddr == OFS_STAT;
    wire rd_sctl = i_s_axi_araddr == OFS_SLV_CTRL;
    wire rd_mctl = i_s_axi_araddr == OFS_MST_CTRL;
    wire rd_inten = (i_s_axi_araddr == OFS_INTEN_SET) | (i_s_axi_araddr == OFS_INTEN_CLR);
    wire rd_sdat = i_s_axi_araddr == OFS_SLV_DATA;
    wire rd_hit = rd_stat | rd_sctl | rd_mctl | rd_inten | rd_sdat | (|rd_sa);
    ise_sctl_t sctl_rd;
    assign sctl_rd = '{rsvd: '0, dma_en: slv_dma_en_r, rsvd2_1: '0, cont: 1'b0};
    wire [DW-1:0] rd_word = ({DW{rd_stat}} & DW'(stat_w))
                          | ({DW{rd_sctl}} & DW'(sctl_rd))
                          | ({DW{rd_inten}} & inten_r)
                          | ({DW{rd_sdat}} & {24'h0, rx_data_r})
                          | sa_or;

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else if (i_s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= rd_word;
        end else if (rvalid_r && i_s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // Clock is grabbed on the detected fall, so the hold starts while the line is low
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            scl_oe_r <= sl_nxt == SL_HOLD;
            sda_oe_r <= sda_oe_nxt;
            irq_r <= |(DW'(stat_w) & inten_r & INT_MASK);
        end
    end

    assign o_s_axi_awready = awready_r;
    assign o_s_axi_wready = wready_r;
    assign o_s_axi_bvalid = bvalid_r;
    assign o_s_axi_bresp = bresp_r;
    assign o_s_axi_arready = arready_r;
    assign o_s_axi_rvalid = rvalid_r;
    assign o_s_axi_rresp = rresp_r;
    assign o_s_axi_rdata = rdata_r;
    // Open drain: only ever pulls low
    assign o_scl_o = 1'b0;
    assign o_sda_o = 1'b0;
    assign o_scl_oe = scl_oe_r;
    assign o_sda_oe = sda_oe_r;
    assign o_dma_req = dma_req_r;
    assign o_irq = irq_r;
endmodule

// ===== rtl/ise_pkg.sv
package ise_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses on the AXI4-Lite port)
    localparam int AW = 8;
    localparam int DW = 32;
    localparam logic [AW-1:0] OFS_SLV_CTRL = 8'h04;
    localparam logic [AW-1:0] OFS_MST_CTRL = 8'h08;
    localparam logic [AW-1:0] OFS_STAT = 8'h0C;
    localparam logic [AW-1:0] OFS_INTEN_SET = 8'h10;
    localparam logic [AW-1:0] OFS_INTEN_CLR = 8'h14;
    localparam logic [AW-1:0] OFS_SLV_DATA = 8'h18;
    localparam logic [AW-1:0] OFS_SLV_ADDR0 = 8'h20;
    localparam logic [AW-1:0] OFS_STEP = 8'h04;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Field layouts
    typedef enum logic [1:0] {
        SLV_CODE_ADDR = 2'h0,
        SLV_CODE_RX = 2'h1,
        SLV_CODE_TX = 2'h2,
        SLV_CODE_RSVD = 2'h3
    } ise_slv_code_t;

    typedef struct packed {
        logic [19:0] rsvd_hi;
        logic slv_nstr;
        ise_slv_code_t slv_code;
        logic slv_pend;
        logic rsvd7;
        logic mst_err;
        logic [1:0] rsvd5_4;
        logic [2:0] mst_code;
        logic mst_pend;
    } ise_stat_t;

    typedef struct packed {
        logic [27:0] rsvd;
        logic dma_en;
        logic [1:0] rsvd2_1;
        logic cont;
    } ise_sctl_t;

    typedef struct packed {
        logic [28:0] rsvd;
        logic stop;
        logic start;
        logic cont;
    } ise_mctl_t;

    typedef struct packed {
        logic [23:0] rsvd;
        logic [6:0] addr;
        logic en;
    } ise_saddr_t;

    // Only the two event flags can raise the interrupt
    localparam logic [DW-1:0] INT_MASK = 32'h0000_0140;

    localparam logic [2:0] MST_CODE_IDLE = 3'h0;
    localparam logic [2:0] MST_CODE_BUSY = 3'h2;

    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        SL_IDLE = 3'h0,
        SL_RX = 3'h1,
        SL_HOLD = 3'h2,
        SL_ACK = 3'h3,
        SL_TX = 3'h4,
        SL_TXACK = 3'h5
    } ise_sl_state_t;

endpackage

// ===== rtl/ise_sync2.sv
module ise_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    // Idle bus lines are high, so both stages reset high
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '1;
            o_sync <= '1;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

// ===== test/ise_bus_model.sv
module ise_bus_model (
    input wire logic i_clk,
    input wire logic i_scl_oe,
    input wire logic i_sda_oe,
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 1ns;
    logic scl_r = 1'b1;
    logic sda_r = 1'b1;
    logic [7:0] got = 8'h00;
    // Wired-and with pull-ups: a released line reads high
    assign o_scl = scl_r & ~i_scl_oe;
    assign o_sda = sda_r & ~i_sda_oe;
    // Four core cycles per half period, 80 ns each; a bit with its extra sample cycle takes 180 ns
    task half;
        repeat (4) @(posedge i_clk);
    endtask
    task bit_(input logic b);
        sda_r <= b;
        half;
        scl_r <= 1'b1;
        @(posedge i_clk);
        while (!o_scl) @(posedge i_clk); // Stretch honoured, no sleep meanwhile
        got <= {got[6:0], o_sda};
        half;
        scl_r <= 1'b0;
    endtask
    task start;
        sda_r <= 1'b1;
        half;
        scl_r <= 1'b1;
        half;
        sda_r <= 1'b0;
        half;
        scl_r <= 1'b0;
    endtask
    task stop;
        sda_r <= 1'b0;
        half;
        scl_r <= 1'b1;
        half;
        sda_r <= 1'b1;
        half;
    endtask
    task sbyte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_(d[i]);
    endtask
endmodule

// ===== test/ise_flags_bench.sv
module ise_flags_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import ise_pkg::*;
    localparam logic [6:0] ADR = 7'h2A;
    logic core_clk, nrst, awv, wv, bready, arv, rready, dma_ack;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rd_v;
    logic [1:0] resp;
    logic [3:0] strb = 4'hF;
    wire logic awr, wrdy, bv, arr, rv, scl_oe, sda_oe, scl, sda, dreq, irq, sclo, sdao;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    ise_flags_top ise_flags_top_inst (.i_core_clk(core_clk), .i_nrst(nrst),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(strb), .i_s_axi_wvalid(wv),
        .o_s_axi_wready(wrdy), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv),
        .o_s_axi_arready(arr), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rv), .i_s_axi_rready(rready), .i_scl(scl), .o_scl_o(sclo),
        .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(sdao), .o_sda_oe(sda_oe),
        .i_dma_ack(dma_ack), .o_dma_req(dreq), .o_irq(irq));
    ise_bus_model bm (.i_clk(core_clk), .i_scl_oe(scl_oe), .i_sda_oe(sda_oe),
        .o_scl(scl), .o_sda(sda));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge core_clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rd_v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task hold_wait;
        while (!scl_oe) @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Ceiling well above the fewer than one thousand cycles the sequence needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            summarize;
        end
    end
    initial begin
        {awv, wv, bready, arv, rready, dma_ack} = 6'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        nrst = 1'b0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(OFS_STAT);
        chk("stat reset", rd_v, 32'h801);
        wr(OFS_SLV_ADDR0, {24'h0, ADR, 1'b1});
        strb <= 4'h0;
        wr(OFS_SLV_ADDR0, 32'h0);
        strb <= 4'hF;
        rd(OFS_SLV_ADDR0);
        chk("lane mask", rd_v, {24'h0, ADR, 1'b1});
        wr(OFS_INTEN_SET, 32'hFFFFFFFF);
        rd(OFS_INTEN_SET);
        chk("enable", rd_v, 32'h140);
        bm.start;
        bm.sbyte({ADR, 1'b0});
        hold_wait;
        rd(OFS_STAT);
        chk("addr hold", rd_v, 32'h101);
        chk("irq set", {31'h0, irq}, 32'h1);
        wr(OFS_STAT, 32'h0);
        rd(OFS_STAT);
        chk("write zero", rd_v, 32'h101);
        wr(OFS_SLV_CTRL, 32'h1);
        bm.bit_(1'b1);
        rd(OFS_STAT);
        chk("continue", rd_v, 32'h801);
        chk("irq low", {31'h0, irq}, 32'h0);
        bm.sbyte(8'h5A);
        hold_wait;
        rd(OFS_STAT);
        chk("rx code", rd_v, 32'h301);
        rd(OFS_SLV_DATA);
        chk("rx byte", rd_v, 32'h5A);
        wr(OFS_SLV_CTRL, 32'h1);
        bm.bit_(1'b1);
        wr(OFS_SLV_CTRL, 32'h8);
        bm.sbyte(8'hC3);
        hold_wait;
        chk("dma req", {31'h0, dreq}, 32'h1);
        rd(OFS_STAT);
        chk("dma pend", rd_v & 32'h100, 32'h0);
        @(posedge core_clk);
        dma_ack <= 1'b1;
        @(posedge core_clk);
        dma_ack <= 1'b0;
        bm.bit_(1'b1);
        bm.stop;
        bm.start;
        bm.sbyte({ADR, 1'b1});
        hold_wait;
        wr(OFS_SLV_DATA, 32'hA5);
        wr(OFS_SLV_CTRL, 32'h1);
        bm.bit_(1'b1);
        hold_wait;
        rd(OFS_STAT);
        chk("tx code", rd_v, 32'h501);
        wr(OFS_SLV_CTRL, 32'h1);
        bm.sbyte(8'hFF);
        chk("tx byte", {24'h0, bm.got}, 32'hA5);
        bm.bit_(1'b1);
        bm.stop;
        for (int k = 0; k < 2; k++) begin
            wr(OFS_MST_CTRL, 32'h2);
            bm.start;
            bm.bit_(1'b0);
            bm.stop;
            rd(OFS_STAT);
            chk("error", rd_v & 32'hCF, 32'h41);
            chk("irq err", {31'h0, irq}, 32'h1);
            if (k == 0) wr(OFS_STAT, 32'h40);
            else wr(OFS_MST_CTRL, 32'h1);
            rd(OFS_STAT);
            chk("err clear", rd_v & 32'h40, 32'h0);
        end
        rd(8'hFC);
        chk("unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
        chk("drain", {30'h0, sclo, sdao}, 32'h0);
        summarize;
    end
endmodule

// ===== test/ise_flags_sva.sv
module ise_flags_sva (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [ise_pkg::AW-1:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic o_s_axi_awready,
    input wire logic [ise_pkg::DW-1:0] o_s_axi_rdata,
    input wire logic o_s_axi_rvalid,
    input wire logic o_s_axi_bvalid,
    input wire logic i_scl,
    input wire logic o_scl_o,
    input wire logic o_scl_oe,
    input wire logic o_sda_o,
    input wire logic o_dma_req
);
    timeunit 1ns;
    timeprecision 1ns;
    import ise_pkg::*;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    logic ar_stat_r;
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) ar_stat_r <= 1'b0;
        else if (i_s_axi_arvalid && o_s_axi_arready) ar_stat_r <= (i_s_axi_araddr == OFS_STAT);
    end
    sequence s_stat_rd;
        $rose(o_s_axi_rvalid) && ar_stat_r;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    nstr_live_a: assert property (s_stat_rd |-> o_s_axi_rdata[11] == !$past(o_scl_oe))
        else $error("not-stretching bit differs from clock hold");
    pend_flag_a: assert property (s_stat_rd |->
        o_s_axi_rdata[8] == ($past(o_scl_oe) && !$past(o_dma_req)))
        else $error("slave pending bit wrong");
    code_rsvd_a: assert property (s_stat_rd |-> o_s_axi_rdata[10:9] != 2'h3)
        else $error("reserved slave code reported");
    dma_hold_a: assert property (o_dma_req |-> o_scl_oe)
        else $error("dma request without clock hold");
    stretch_low_a: assert property ($rose(o_scl_oe) |-> !$past(i_scl))
        else $error("stretch began with clock high");
    drain_only_a: assert property (!o_scl_o && !o_sda_o)
        else $error("bus line driven high");
    rd_answer_a: assert property ($rose(o_s_axi_rvalid) |-> $past(i_s_axi_arvalid && o_s_axi_arready))
        else $error("read answer not one cycle after address");
    wr_busy_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready)
        else $error("write address taken during response");
endmodule
bind ise_flags_top ise_flags_sva ise_flags_sva_inst (.i_core_clk, .i_nrst, .i_s_axi_araddr,
    .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_awready, .o_s_axi_rdata, .o_s_axi_rvalid,
    .o_s_axi_bvalid, .i_scl, .o_scl_o, .o_scl_oe, .o_sda_o, .o_dma_req);
